// ==== include/emcfg_pkg.sv ====
// Purpose: Constants for the energy measurement mode/config register bank
// Assumes: 7-bit indirect pointer, 8-bit data port, 16-bit registers split in byte halves
// Notes on behaviour
// R01 - Writing one to mode A bit 7 restores every bank register to default.
// R02 - Mode A bit 6 high bypasses zero-crossing lowpass filter.
// R03 - Mode A bit 5 high inserts integrator in current path.
// R04 - Mode A bit 4 high swaps first and second channel converter outputs.
// R05 - Mode A bit 3 high powers down voltage and current converters.
// R06 - Mode A bit 2 defaults one and disables pulse output B.
// R07 - Mode A bit 1 defaults one and disables pulse output A.
// R08 - Mode A bit 0 high bypasses both high-pass filters.
// R09 - Mode B bits 7-6 pick pulse B source; default reactive.
// R10 - Mode B bits 5-4 pick pulse A source; default active.
// R11 - For code 1x, mode B bit 3 picks apparent (0) or rms current (1).
// R12 - Software must not mix apparent and rms current across the two outputs.
// R13 - Mode B bit 2 high syncs rms updates to voltage zero crossings.
// R14 - Mode B bit 1 low makes line measurement hold the period.
// R15 - Mode B bit 1 high makes line measurement hold frequency.
// R16 - Software always writes one to reserved mode B bit 0.
// R17 - Pulse A denominator 16 bits resets 0x003f; numerator resets zero.
// R18 - Pulse B denominator 16 bits resets 0x003f; numerator resets zero.
// R19 - Reactive divisor, 8 bits at pointer 0x25, resets zero.
// R20 - Apparent divisor, 8 bits at pointer 0x26, resets zero.
// R21 - Soft reset bit clears itself after defaults restored.
package emcfg_pkg;
  localparam int          ADDR_W        = 7;
  localparam logic [6:0]  ADDR_MODE_A   = 7'h0b;
  localparam logic [6:0]  ADDR_MODE_B   = 7'h0c;
  localparam logic [6:0]  ADDR_VAR_DIV  = 7'h25;
  localparam logic [6:0]  ADDR_VA_DIV   = 7'h26;
  localparam logic [6:0]  ADDR_A_NUM    = 7'h27;
  localparam logic [6:0]  ADDR_A_DEN    = 7'h28;
  localparam logic [6:0]  ADDR_B_NUM    = 7'h29;
  localparam logic [6:0]  ADDR_B_DEN    = 7'h2a;
  localparam logic [6:0]  ADDR_CAL_MODE = 7'h3d;
  localparam logic [7:0]  RST_MODE_A    = 8'h06;
  localparam logic [7:0]  RST_MODE_B    = 8'h40;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [15:0] RST_NUM       = 16'h0000;
  localparam logic [15:0] RST_DEN       = 16'h003f;
  localparam int          BIT_SOFT_RST  = 7;
  localparam int          BIT_ZX_BYP    = 6;
  localparam int          BIT_INTEG     = 5;
  localparam int          BIT_SWAP      = 4;
  localparam int          BIT_CONVERTER_POWER_DOWN     = 3;
  localparam int          BIT_B_DIS     = 2;
  localparam int          BIT_A_DIS     = 1;
  localparam int          BIT_HPF_BYP   = 0;
  localparam int          SRC_B_HI      = 7;
  localparam int          SRC_A_HI      = 5;
  localparam int          BIT_RMS_CHO   = 3;
  localparam int          BIT_ZX_RMS    = 2;
  localparam int          BIT_FREQ_SEL  = 1;
  // Pulse source decoded
  typedef enum logic [1:0] {
    SRC_ACTIVE   = 2'h0,
    SRC_REACTIVE = 2'h1,
    SRC_APPARENT = 2'h2,
    SRC_IRMS     = 2'h3
  } pulse_src_t;
endpackage

// ==== hdl/emcfg_word16.sv ====
// Purpose: One 16-bit register written a byte at a time
// Assumes: hiSel picks the upper byte
// Notes: Soft reset returns the reset value
`timescale 1ns/100ps
module emcfg_word16 #(
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  input  wire logic        ref_clk,  // Clock
  input  wire logic        nrst,     // Async reset, low
  input  wire logic        softRst,  // Restore default
  input  wire logic        wrEn,     // Write strobe
  input  wire logic        hiSel,    // Upper byte select
  input  wire logic [7:0]  wrData,   // Write byte
  output logic      [15:0] value     // Stored word
);
  logic [15:0] word_ff;
  logic [15:0] nxt_word;

  always_comb
  begin
    nxt_word = word_ff;
    if (softRst)
      nxt_word = RST_VAL;  // [R17] [R18]
    else if (wrEn && hiSel)
      nxt_word[15:8] = wrData;
    else if (wrEn)
      nxt_word[7:0] = wrData;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      word_ff <= RST_VAL;  // [R17] [R18]
    else
      word_ff <= nxt_word;
  end

  assign value = word_ff;
endmodule

// ==== hdl/emcfg_src_decode.sv ====
// Purpose: Decodes a pulse output's 2-bit source code
// Assumes: Apparent/rms choice is shared by both outputs
// Notes: Shared choice is why both cannot differ
`timescale 1ns/100ps
module emcfg_src_decode (
  input  wire logic [1:0]           code,     // Source code field
  input  wire logic                 rmsCho,   // Apparent or rms choice
  output emcfg_pkg::pulse_src_t     source    // Decoded source
);
  always_comb
  begin
    if (code[1])
      source = rmsCho ? emcfg_pkg::SRC_IRMS : emcfg_pkg::SRC_APPARENT;  // [R11]
    else if (code[0])
      source = emcfg_pkg::SRC_REACTIVE;
    else
      source = emcfg_pkg::SRC_ACTIVE;
  end
endmodule

// ==== hdl/energy_meter_mode_config_bank.sv ====
// Purpose: Mode and scaling configuration bank behind the indirect pointer
// Assumes: Software writes pointer, then data; 16-bit regs take hiSel per byte
// Notes: Soft reset returns bank to defaults in one cycle then self-clears
`timescale 1ns/100ps
module energy_meter_mode_config_bank (
  input  wire logic                   ref_clk,            // 250 MHz clock
  input  wire logic                   nrst,               // Async reset, low
  input  wire logic [6:0]             addrPtr,            // Indirect address pointer
  input  wire logic                   wrStrobe,           // Write data strobe
  input  wire logic                   hiSel,              // Upper byte of 16-bit reg
  input  wire logic [7:0]             wrData,             // Write data
  output logic      [7:0]             rdData,             // Read data, registered
  output logic                        bankReset,          // Measurement regs to default
  output logic                        zeroCrossFilterBypass, // Bypass ZX lowpass
  output logic                        integratorEnable,   // Integrator on current
  output logic                        channelSwap,        // Swap converter outputs
  output logic                        converterPowerDown, // Converters off
  output logic                        pulseAEnable,       // Pulse output A enable
  output logic                        pulseBEnable,       // Pulse output B enable
  output logic                        highpassBypass,     // Bypass high-pass filters
  output emcfg_pkg::pulse_src_t       pulseASource,       // Pulse A source
  output emcfg_pkg::pulse_src_t       pulseBSource,       // Pulse B source
  output logic                        rmsZeroCrossSync,   // Rms update on ZX
  output logic                        lineMeasFrequency,  // 1 freq, 0 period
  output logic      [7:0]             reactiveEnergyDivisor, // Reactive scaling
  output logic      [7:0]             apparentEnergyDivisor, // Apparent scaling
  output logic      [15:0]            pulseANumerator,    // Pulse A numerator
  output logic      [15:0]            pulseADenominator,  // Pulse A denominator
  output logic      [15:0]            pulseBNumerator,    // Pulse B numerator
  output logic      [15:0]            pulseBDenominator,  // Pulse B denominator
  output logic      [7:0]             calibrationMode     // Calibration mode
);
  logic [7:0]            modeA_ff;
  logic [7:0]            nxt_modeA;
  logic [7:0]            modeB_ff;
  logic [7:0]            nxt_modeB;
  logic [7:0]            reactive_energy_divisor_ff;
  logic [7:0]            nxt_reactive_energy_divisor;
  logic [7:0]            apparent_energy_divisor_ff;
  logic [7:0]            nxt_apparent_energy_divisor;
  logic [7:0]            calibration_mode_ff;
  logic [7:0]            nxt_calibration_mode;
  logic [7:0]            rdData_ff;
  logic [7:0]            nxt_rdData;
  logic                  softRst;
  logic                  wrModeA;
  logic                  wrModeB;
  logic                  wrVarDiv;
  logic                  wrVaDiv;
  logic                  wrCalMode;
  logic [15:0]           words [4];
  logic [3:0]            wordWr;
  logic                  zxByp_ff;
  logic                  nxt_zxByp;
  logic                  integ_ff;
  logic                  nxt_integ;
  logic                  swap_ff;
  logic                  nxt_swap;
  logic                  converter_power_down_ff;
  logic                  nxt_converter_power_down;
  logic                  aEn_ff;
  logic                  nxt_aEn;
  logic                  bEn_ff;
  logic                  nxt_bEn;
  logic                  hpfByp_ff;
  logic                  nxt_hpfByp;
  logic                  rms_zero_cross_sync_ff;
  logic                  nxt_rms_zero_cross_sync;
  logic                  period_frequency_select_ff;
  logic                  nxt_period_frequency_select;
  emcfg_pkg::pulse_src_t srcA_ff;
  emcfg_pkg::pulse_src_t nxt_srcA;
  emcfg_pkg::pulse_src_t srcB_ff;
  emcfg_pkg::pulse_src_t nxt_srcB;

  // Strobe passed in: a continuous assign only wakes on its arguments
  function automatic logic hit(input logic       stb,
                               input logic [6:0] ptr,
                               input logic [6:0] regAddr);
    hit = stb && (ptr == regAddr);
  endfunction

  // Bit 7 stored for one cycle is the soft reset pulse
  assign softRst = modeA_ff[emcfg_pkg::BIT_SOFT_RST];  // [R01]

  // A write landing in the soft reset cycle is lost; defaults win
  always_comb
  begin
    wrModeA   = hit(wrStrobe, addrPtr, emcfg_pkg::ADDR_MODE_A) && !softRst;
    wrModeB   = hit(wrStrobe, addrPtr, emcfg_pkg::ADDR_MODE_B) && !softRst;
    wrVarDiv  = hit(wrStrobe, addrPtr, emcfg_pkg::ADDR_VAR_DIV) && !softRst;
    wrVaDiv   = hit(wrStrobe, addrPtr, emcfg_pkg::ADDR_VA_DIV) && !softRst;
    wrCalMode = hit(wrStrobe, addrPtr, emcfg_pkg::ADDR_CAL_MODE) && !softRst;
  end

  // Mode A; the restore that bit 7 triggers also drops bit 7
  always_comb
  begin
    nxt_modeA = modeA_ff;
    if (softRst)
      nxt_modeA = emcfg_pkg::RST_MODE_A;  // [R01] [R21]
    else if (wrModeA)
      nxt_modeA = wrData;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      modeA_ff <= emcfg_pkg::RST_MODE_A;  // [R06] [R07]
    else
      modeA_ff <= nxt_modeA;
  end

  always_comb
  begin
    nxt_modeB = modeB_ff;
    if (softRst)
      nxt_modeB = emcfg_pkg::RST_MODE_B;  // [R01]
    else if (wrModeB)
      nxt_modeB = wrData;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      modeB_ff <= emcfg_pkg::RST_MODE_B;  // [R09] [R10]
    else
      modeB_ff <= nxt_modeB;
  end

  always_comb
  begin
    nxt_reactive_energy_divisor = reactive_energy_divisor_ff;
    if (softRst)
      nxt_reactive_energy_divisor = emcfg_pkg::RST_BYTE;  // [R01]
    else if (wrVarDiv)
      nxt_reactive_energy_divisor = wrData;  // [R19]
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      reactive_energy_divisor_ff <= emcfg_pkg::RST_BYTE;  // [R19]
    else
      reactive_energy_divisor_ff <= nxt_reactive_energy_divisor;
  end

  always_comb
  begin
    nxt_apparent_energy_divisor = apparent_energy_divisor_ff;
    if (softRst)
      nxt_apparent_energy_divisor = emcfg_pkg::RST_BYTE;  // [R01]
    else if (wrVaDiv)
      nxt_apparent_energy_divisor = wrData;  // [R20]
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      apparent_energy_divisor_ff <= emcfg_pkg::RST_BYTE;  // [R20]
    else
      apparent_energy_divisor_ff <= nxt_apparent_energy_divisor;
  end

  always_comb
  begin
    nxt_calibration_mode = calibration_mode_ff;
    if (softRst)
      nxt_calibration_mode = emcfg_pkg::RST_BYTE;  // [R01]
    else if (wrCalMode)
      nxt_calibration_mode = wrData;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      calibration_mode_ff <= emcfg_pkg::RST_BYTE;
    else
      calibration_mode_ff <= nxt_calibration_mode;
  end

  // Four 16-bit pulse scaling registers, pointer 0x27..0x2a in order
  localparam logic [15:0] WORD_RST [4] = '{emcfg_pkg::RST_NUM, emcfg_pkg::RST_DEN,
                                           emcfg_pkg::RST_NUM, emcfg_pkg::RST_DEN};
  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_word
      assign wordWr[i] = hit(wrStrobe, addrPtr, emcfg_pkg::ADDR_A_NUM + 7'(i)) && !softRst;
      emcfg_word16 #(
        .RST_VAL (WORD_RST[i])
      ) u_word (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .softRst (softRst),   // [R01]
        .wrEn    (wordWr[i]),
        .hiSel   (hiSel),
        .wrData  (wrData),
        .value   (words[i])
      );
    end
  endgenerate

  // Registered readback; unmapped pointers read zero
  always_comb
  begin
    nxt_rdData = 8'h00;
    unique case (addrPtr)
      emcfg_pkg::ADDR_MODE_A:   nxt_rdData = modeA_ff;
      emcfg_pkg::ADDR_MODE_B:   nxt_rdData = modeB_ff;
      emcfg_pkg::ADDR_VAR_DIV:  nxt_rdData = reactive_energy_divisor_ff;
      emcfg_pkg::ADDR_VA_DIV:   nxt_rdData = apparent_energy_divisor_ff;
      emcfg_pkg::ADDR_A_NUM:    nxt_rdData = hiSel ? words[0][15:8] : words[0][7:0];
      emcfg_pkg::ADDR_A_DEN:    nxt_rdData = hiSel ? words[1][15:8] : words[1][7:0];
      emcfg_pkg::ADDR_B_NUM:    nxt_rdData = hiSel ? words[2][15:8] : words[2][7:0];
      emcfg_pkg::ADDR_B_DEN:    nxt_rdData = hiSel ? words[3][15:8] : words[3][7:0];
      emcfg_pkg::ADDR_CAL_MODE: nxt_rdData = calibration_mode_ff;
      default:                  nxt_rdData = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rdData_ff <= 8'h00;
    else
      rdData_ff <= nxt_rdData;
  end

  emcfg_src_decode u_srcA (
    .code   (nxt_modeB[emcfg_pkg::SRC_A_HI -: 2]),  // [R10]
    .rmsCho (nxt_modeB[emcfg_pkg::BIT_RMS_CHO]),
    .source (nxt_srcA)
  );

  emcfg_src_decode u_srcB (
    .code   (nxt_modeB[emcfg_pkg::SRC_B_HI -: 2]),  // [R09]
    .rmsCho (nxt_modeB[emcfg_pkg::BIT_RMS_CHO]),    // Shared, so no mixing [R12]
    .source (nxt_srcB)
  );

  // Output flops load from next mode values, so they move with the registers
  always_comb
  begin
    nxt_zxByp   = nxt_modeA[emcfg_pkg::BIT_ZX_BYP];    // [R02]
    nxt_integ   = nxt_modeA[emcfg_pkg::BIT_INTEG];     // [R03]
    nxt_swap    = nxt_modeA[emcfg_pkg::BIT_SWAP];      // [R04]
    nxt_converter_power_down   = nxt_modeA[emcfg_pkg::BIT_CONVERTER_POWER_DOWN];     // [R05]
    nxt_bEn     = !nxt_modeA[emcfg_pkg::BIT_B_DIS];    // [R06]
    nxt_aEn     = !nxt_modeA[emcfg_pkg::BIT_A_DIS];    // [R07]
    nxt_hpfByp  = nxt_modeA[emcfg_pkg::BIT_HPF_BYP];   // [R08]
    nxt_rms_zero_cross_sync   = nxt_modeB[emcfg_pkg::BIT_ZX_RMS];    // [R13]
    nxt_period_frequency_select = nxt_modeB[emcfg_pkg::BIT_FREQ_SEL];  // [R14] [R15]
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      zxByp_ff   <= emcfg_pkg::RST_MODE_A[emcfg_pkg::BIT_ZX_BYP];
      integ_ff   <= emcfg_pkg::RST_MODE_A[emcfg_pkg::BIT_INTEG];
      swap_ff    <= emcfg_pkg::RST_MODE_A[emcfg_pkg::BIT_SWAP];
      converter_power_down_ff   <= emcfg_pkg::RST_MODE_A[emcfg_pkg::BIT_CONVERTER_POWER_DOWN];
      bEn_ff     <= !emcfg_pkg::RST_MODE_A[emcfg_pkg::BIT_B_DIS];  // [R06]
      aEn_ff     <= !emcfg_pkg::RST_MODE_A[emcfg_pkg::BIT_A_DIS];  // [R07]
      hpfByp_ff  <= emcfg_pkg::RST_MODE_A[emcfg_pkg::BIT_HPF_BYP];
      rms_zero_cross_sync_ff   <= emcfg_pkg::RST_MODE_B[emcfg_pkg::BIT_ZX_RMS];
      period_frequency_select_ff <= emcfg_pkg::RST_MODE_B[emcfg_pkg::BIT_FREQ_SEL];
      srcA_ff    <= emcfg_pkg::SRC_ACTIVE;    // [R10]
      srcB_ff    <= emcfg_pkg::SRC_REACTIVE;  // [R09]
    end
    else
    begin
      zxByp_ff   <= nxt_zxByp;
      integ_ff   <= nxt_integ;
      swap_ff    <= nxt_swap;
      converter_power_down_ff   <= nxt_converter_power_down;
      bEn_ff     <= nxt_bEn;
      aEn_ff     <= nxt_aEn;
      hpfByp_ff  <= nxt_hpfByp;
      rms_zero_cross_sync_ff   <= nxt_rms_zero_cross_sync;
      period_frequency_select_ff <= nxt_period_frequency_select;
      srcA_ff    <= nxt_srcA;
      srcB_ff    <= nxt_srcB;
    end
  end

  assign rdData                = rdData_ff;
  assign bankReset             = softRst;                                  // [R01]
  assign zeroCrossFilterBypass = zxByp_ff;    // [R02]
  assign integratorEnable      = integ_ff;    // [R03]
  assign channelSwap           = swap_ff;     // [R04]
  assign converterPowerDown    = converter_power_down_ff;    // [R05]
  assign pulseBEnable          = bEn_ff;      // [R06]
  assign pulseAEnable          = aEn_ff;      // [R07]
  assign highpassBypass        = hpfByp_ff;   // [R08]
  assign pulseASource          = srcA_ff;     // [R10] [R11]
  assign pulseBSource          = srcB_ff;     // [R09] [R11]
  assign rmsZeroCrossSync      = rms_zero_cross_sync_ff;    // [R13]
  assign lineMeasFrequency     = period_frequency_select_ff;  // [R14] [R15]
  assign reactiveEnergyDivisor = reactive_energy_divisor_ff;
  assign apparentEnergyDivisor = apparent_energy_divisor_ff;
  assign pulseANumerator       = words[0];
  assign pulseADenominator     = words[1];
  assign pulseBNumerator       = words[2];
  assign pulseBDenominator     = words[3];
  assign calibrationMode       = calibration_mode_ff;
endmodule

// ==== testbench/emcfg_bank_sva.sv ====
// Purpose: Port-level checks for the mode and scaling bank
// Assumes: Writes taken on rising edge; defaults land one cycle after bankReset
// Notes: Writes seen while bankReset is high are dropped, so excluded here
`timescale 1ns/100ps
module emcfg_bank_sva (
  input wire logic                  ref_clk, nrst, wrStrobe, hiSel, bankReset,
  input wire logic [6:0]            addrPtr,
  input wire logic [7:0]            wrData, rdData, reactiveEnergyDivisor,
  input wire logic                  zeroCrossFilterBypass, integratorEnable, channelSwap,
  input wire logic                  converterPowerDown, pulseAEnable, pulseBEnable,
  input wire logic                  highpassBypass, rmsZeroCrossSync, lineMeasFrequency,
  input wire emcfg_pkg::pulse_src_t pulseASource, pulseBSource,
  input wire logic [15:0]           pulseANumerator, pulseADenominator, pulseBDenominator
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic wr;
  assign wr = wrStrobe && !bankReset;
  mode_a_ctrl_a: assert property (wr && addrPtr == 7'h0b |=>
    {zeroCrossFilterBypass, integratorEnable, channelSwap, converterPowerDown, !pulseBEnable,
     !pulseAEnable, highpassBypass} == $past(wrData[6:0])) else $error("mode A output wrong");
  soft_reset_a: assert property (wr && addrPtr == 7'h0b && wrData[7] |=> bankReset ##1
    (!bankReset && pulseADenominator == 16'h003f && !pulseAEnable && reactiveEnergyDivisor == 8'h00
     && pulseBSource == emcfg_pkg::SRC_REACTIVE)) else $error("soft reset defaults wrong");
  reset_pulse_a: assert property (bankReset |=> !bankReset) else $error("bankReset too long");
  source_b_a: assert property (wr && addrPtr == 7'h0c |=> pulseBSource ==
    ($past(wrData[7]) ? {1'b1, $past(wrData[3])} : {1'b0, $past(wrData[6])}))
    else $error("pulse B source wrong");
  source_a_a: assert property (wr && addrPtr == 7'h0c |=> pulseASource ==
    ($past(wrData[5]) ? {1'b1, $past(wrData[3])} : {1'b0, $past(wrData[4])}))
    else $error("pulse A source wrong");
  mode_b_bits_a: assert property (wr && addrPtr == 7'h0c |=>
    {rmsZeroCrossSync, lineMeasFrequency} == $past(wrData[2:1])) else $error("mode B bits wrong");
  divisor_write_a: assert property (wr && addrPtr == 7'h25 |=>
    reactiveEnergyDivisor == $past(wrData)) else $error("divisor write wrong");
  num_high_a: assert property (wr && addrPtr == 7'h27 && hiSel |=>
    pulseANumerator == {$past(wrData), $past(pulseANumerator[7:0])}) else $error("high byte wrong");
  den_hold_a: assert property (!wrStrobe && !bankReset |=> $stable(pulseBDenominator))
    else $error("denominator changed without write");
  unmapped_read_a: assert property (addrPtr == 7'h7f |=> rdData == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind energy_meter_mode_config_bank emcfg_bank_sva chk (.ref_clk, .nrst, .wrStrobe, .hiSel,
  .bankReset, .addrPtr, .wrData, .rdData, .reactiveEnergyDivisor, .zeroCrossFilterBypass,
  .integratorEnable, .channelSwap, .converterPowerDown, .pulseAEnable, .pulseBEnable,
  .highpassBypass, .rmsZeroCrossSync, .lineMeasFrequency, .pulseASource, .pulseBSource,
  .pulseANumerator, .pulseADenominator, .pulseBDenominator);

// ==== testbench/test_energy_meter_mode_config_bank.sv ====
// Purpose: Self-checking bench for the mode and scaling bank
// Assumes: Inputs change on falling edge; rdData read one cycle after the pointer
// Notes: Strobe drops between writes so each byte is its own pulse
`timescale 1ns/100ps
module test_energy_meter_mode_config_bank;
  logic                  ref_clk = 1'b0, nrst = 1'b0, wrStrobe = 1'b0, hiSel = 1'b0;
  logic [6:0]            addrPtr = 7'h00;
  logic [7:0]            wrData = 8'h00, rdData, reactiveEnergyDivisor, apparentEnergyDivisor;
  logic [7:0]            calibrationMode, v;
  logic                  bankReset, zeroCrossFilterBypass, integratorEnable, channelSwap;
  logic                  converterPowerDown, pulseAEnable, pulseBEnable, highpassBypass;
  logic                  rmsZeroCrossSync, lineMeasFrequency;
  emcfg_pkg::pulse_src_t pulseASource, pulseBSource;
  logic [15:0]           pulseANumerator, pulseADenominator, pulseBNumerator, pulseBDenominator;
  int                    nErrors = 0, testsRun = 0;
  always #2 ref_clk = ~ref_clk;
  energy_meter_mode_config_bank dut (.ref_clk, .nrst, .addrPtr, .wrStrobe, .hiSel, .wrData,
    .rdData, .bankReset, .zeroCrossFilterBypass, .integratorEnable, .channelSwap,
    .converterPowerDown, .pulseAEnable, .pulseBEnable, .highpassBypass, .pulseASource,
    .pulseBSource, .rmsZeroCrossSync, .lineMeasFrequency, .reactiveEnergyDivisor,
    .apparentEnergyDivisor, .pulseANumerator, .pulseADenominator, .pulseBNumerator,
    .pulseBDenominator, .calibrationMode);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic h);
    @(negedge ref_clk);
    addrPtr = a;
    wrData = d;
    hiSel = h;
    wrStrobe = 1'b1;
    @(negedge ref_clk);
    wrStrobe = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic h);
    @(negedge ref_clk);
    addrPtr = a;
    hiSel = h;
    @(negedge ref_clk);
    v = rdData;
  endtask
  function automatic logic [1:0] src(input logic [1:0] code, input logic cho);
    return code[1] ? {1'b1, cho} : {1'b0, code[0]};
  endfunction
  task automatic t_defaults();
    chk({pulseAEnable, pulseBEnable, pulseBSource, pulseASource}, 16'h0004);
    chk(pulseADenominator, 16'h003f);
    chk(pulseBDenominator, 16'h003f);
    chk(pulseANumerator, 16'h0000);
    chk(pulseBNumerator, 16'h0000);
    chk({reactiveEnergyDivisor, apparentEnergyDivisor}, 16'h0000);
    rd(7'h0b, 1'b0);
    chk(v, 16'h0006);
    rd(7'h0c, 1'b0);
    chk(v, 16'h0040);
  endtask
  task automatic t_mode_a();
    logic [7:0] d;
    for (int i = 0; i < 7; i++)
    begin
      d = 8'h01 << i;
      wr(7'h0b, d, 1'b0);
      chk({zeroCrossFilterBypass, integratorEnable, channelSwap, converterPowerDown,
           ~pulseBEnable, ~pulseAEnable, highpassBypass}, {9'h000, d[6:0]});
    end
  endtask
  task automatic t_mode_b();
    logic [7:0] d;
    for (int c = 0; c < 8; c++)
    begin
      d = {c[2:1], 2'(c[2:1] + 2'h1), c[0], c[1], c[2], 1'b1};
      wr(7'h0c, d, 1'b0);
      chk({pulseBSource, pulseASource, rmsZeroCrossSync, lineMeasFrequency},
          {src(d[7:6], d[3]), src(d[5:4], d[3]), d[2:1]});
      rd(7'h0c, 1'b0);
      chk(v, d);
    end
  endtask
  task automatic t_regs();
    logic [6:0] adr [7] = '{7'h25, 7'h26, 7'h27, 7'h28, 7'h29, 7'h2a, 7'h3d};
    for (int i = 0; i < 7; i++)
    begin
      wr(adr[i], 8'h50 + 8'(i), 1'b1);
      wr(adr[i], 8'ha0 + 8'(i), 1'b0);
      rd(adr[i], 1'b0);
      chk(v, 16'h00a0 + 16'(i));
      rd(adr[i], 1'b1);
      chk(v, (i >= 2 && i <= 5) ? 16'h0050 + 16'(i) : 16'h00a0 + 16'(i));
    end
    chk({reactiveEnergyDivisor, apparentEnergyDivisor}, 16'ha0a1);
    chk(pulseANumerator, 16'h52a2);
    chk(pulseADenominator, 16'h53a3);
    chk(pulseBNumerator, 16'h54a4);
    chk(pulseBDenominator, 16'h55a5);
    chk(calibrationMode, 16'h00a6);
    wr(7'h7f, 8'hff, 1'b0);
    chk({reactiveEnergyDivisor, apparentEnergyDivisor}, 16'ha0a1);
    rd(7'h7f, 1'b0);
    chk(v, 16'h0000);
  endtask
  task automatic t_soft_rst();
    wr(7'h0c, 8'hcf, 1'b0);
    wr(7'h0b, 8'h80, 1'b0);
    chk(bankReset, 16'h0001);
    @(negedge ref_clk);
    chk(bankReset, 16'h0000);
    chk(pulseADenominator, 16'h003f);
    chk({reactiveEnergyDivisor, calibrationMode}, 16'h0000);
    chk(pulseBSource, emcfg_pkg::SRC_REACTIVE);
    rd(7'h0b, 1'b0);
    chk(v, 16'h0006);
    rd(7'h2a, 1'b1);
    chk(v, 16'h0000);
  endtask
  // Mid-run reset with modes away from default; outputs checked at defaults after two cycles held in reset
  task automatic t_reset();
    @(negedge ref_clk);
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({pulseAEnable, pulseBEnable, pulseBSource, pulseASource}, 16'h0004);
    chk({zeroCrossFilterBypass, lineMeasFrequency, rmsZeroCrossSync}, 16'h0000);
    nrst = 1'b1;
    t_defaults();
  endtask
  task automatic finalReport();
    $display("Checks %0d errors %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'b1;
    t_defaults();
    t_mode_a();
    t_mode_b();
    t_reset();
    t_regs();
    t_soft_rst();
    finalReport();
  end
  // Whole run is well under 300 cycles
  initial
  begin
    #20000;
    nErrors++;
    finalReport();
  end
endmodule
